// ==== verilog/fmac_top.sv ====
/*
  Fault monitor and on-chip converter control with APB register access.
  Assumes a converter on the core clock that pulses adc_done with a valid code,
  codes rising with temperature and with loop sense voltage, and static straps.
*/
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps

module fmac_top
  import fmac_pkg::*;
#(
  parameter int          ADC_W    = 12,
  parameter logic [11:0] HOT_CODE = 12'hA00,
  parameter logic [11:0] OVH_CODE = 12'hC00,
  parameter logic [11:0] LOW_SET  = 12'h3D6,
  parameter logic [11:0] LOW_CLR  = 12'h47B,
  parameter logic [11:0] CRIT_SET = 12'h1EB,
  parameter logic [11:0] CRIT_CLR = 12'h28F
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // APB slave
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // On-chip converter
  input  wire logic             adc_done,
  input  wire logic [ADC_W-1:0] adc_result,
  output logic                  adc_power_on,
  output logic                  adc_source_temp,
  output logic                  adc_start,
  // Strap pins
  input  wire logic             span_sel_msb,
  input  wire logic             span_sel_lsb,
  input  wire logic             regulator_level_bit2,
  input  wire logic             regulator_level_bit1,
  input  wire logic             regulator_level_bit0,
  // Decoded straps
  output logic      [1:0]       span_code,
  output logic      [7:0]       regulator_decivolts,
  output logic                  regulator_level_unsupported,
  // Alerts
  output logic                  fault_alert,
  output logic                  irq
);

  fmac_strap_if #(.W(5)) straps ();

  fmac_adc_state_t  st_q, st_d;
  logic [9:0]       ctrl_q, ctrl_d;
  logic [ST_W-1:0]  stat_q, stat_d, mask_q, mask_d, ev;
  logic             req_q, req_d, src_lat_q, src_lat_d, irq_q, irq_d;
  logic             rdy_q, rdy_d, err_q, err_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [ADC_W-1:0] res_q, res_d;
  logic             hot_q, hot_d, ovh_q, ovh_d, low_q, low_d, crit_q, crit_d;
  logic             alert_q, alert_d, flt_src_q, flt_src_d;
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic [1:0]       span_q, span_d;
  logic [7:0]       lvl_q, lvl_d;
  logic             unsup_q, unsup_d;
  logic             acc, wr, rd, hit, cmd_conv, blank, done_ok;

  assign straps.raw = {span_sel_msb, span_sel_lsb,
                       regulator_level_bit2, regulator_level_bit1, regulator_level_bit0};

  fmac_strap_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .straps   (straps)
  );

  // Access phase; one wait state so every answer leaves a flip-flop
  assign acc      = psel & penable;
  assign wr       = acc & pready & pwrite;
  assign rd       = acc & ~rdy_q & ~pwrite;
  assign hit      = (paddr == OFF_CTRL) || (paddr == OFF_CMD) || (paddr == OFF_FAULT) ||
                    (paddr == OFF_STRAP) || (paddr == OFF_STATUS) || (paddr == OFF_MASK);
  assign cmd_conv = wr && (paddr == OFF_CMD) && (pwdata[7:0] == CMD_CONVERT);
  assign blank    = (settle_q != '0);
  assign done_ok  = (st_q == ADC_WAIT) && adc_done && !blank;

  // Bus registers, status and interrupt
  always_comb begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    rdy_d   = acc & ~rdy_q;
    err_d   = acc & ~rdy_q & ~hit;
    rdata_d = rdata_q;
    ev      = '0;
    ev[ST_HOT]  = hot_d & ~hot_q;
    ev[ST_OVH]  = ovh_d & ~ovh_q;
    ev[ST_LOW]  = low_d & ~low_q;
    ev[ST_CRIT] = crit_d & ~crit_q;
    ev[ST_CONV] = done_ok;
    stat_d = stat_q;
    if (wr && paddr == OFF_CTRL) begin
      ctrl_d = pwdata[9:0];
    end else if (wr && paddr == OFF_MASK) begin
      mask_d = pwdata[ST_W-1:0];
    end else if (wr && paddr == OFF_STATUS) begin
      stat_d = stat_q & ~pwdata[ST_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    stat_d = stat_d | ev;
    irq_d  = |(stat_d & mask_d);
    if (rd) begin
      rdata_d = '0;
      if (paddr == OFF_CTRL) begin
        rdata_d[9:0] = ctrl_q;
      end else if (paddr == OFF_FAULT) begin
        rdata_d[ADC_W-1:0]   = res_q;
        rdata_d[FLT_HOT_BIT]  = hot_q;
        rdata_d[FLT_OVH_BIT]  = ovh_q;
        rdata_d[FLT_LOW_BIT]  = low_q;
        rdata_d[FLT_CRIT_BIT] = crit_q;
        rdata_d[FLT_SRC_BIT]  = flt_src_q;
      end else if (paddr == OFF_STRAP) begin
        rdata_d[1:0]                         = span_q;
        rdata_d[STR_LEVEL_LSB+2:STR_LEVEL_LSB] = straps.clean[2:0];
        rdata_d[STR_UNSUP_BIT]               = unsup_q;
      end else if (paddr == OFF_STATUS) begin
        rdata_d[ST_W-1:0] = stat_q;
      end else if (paddr == OFF_MASK) begin
        rdata_d[ST_W-1:0] = mask_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q  <= CTRL_RST;
      mask_q  <= MASK_RST;
      stat_q  <= '0;
      irq_q   <= 1'b0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      mask_q  <= mask_d;
      stat_q  <= stat_d;
      irq_q   <= irq_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // Conversion sequencer: one-shot on command, free running in auto readback while converter power is set
  always_comb begin
    st_d      = st_q;
    req_d     = req_q | cmd_conv;
    src_lat_d = src_lat_q;
    settle_d  = blank ? settle_q - 1'b1 : settle_q;
    // Loop to temperature switch opens the settling window
    if (ctrl_q[CTRL_SRC_BIT] != SRC_TEMP && ctrl_d[CTRL_SRC_BIT] == SRC_TEMP) begin
      settle_d = SETTLE_W'(SETTLE_CYC);
    end
    case (st_q)
      ADC_IDLE: begin
        if (req_q || (ctrl_q[CTRL_AUTO_BIT] && ctrl_q[CTRL_PWR_BIT])) begin
          st_d      = ADC_START;
          src_lat_d = ctrl_q[CTRL_SRC_BIT];
          req_d     = cmd_conv;
        end
      end
      ADC_START: begin
        st_d = ADC_WAIT;
      end
      ADC_WAIT: begin
        if (adc_done) begin
          st_d = ADC_IDLE;
        end
      end
      default: begin
        st_d = ADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q      <= ADC_IDLE;
      req_q     <= 1'b0;
      src_lat_q <= 1'b0;
      settle_q  <= '0;
    end else begin
      st_q      <= st_d;
      req_q     <= req_d;
      src_lat_q <= src_lat_d;
      settle_q  <= settle_d;
    end
  end

  // Flags and result; a blanked conversion is dropped whole
  always_comb begin
    res_d  = res_q;
    hot_d  = hot_q;
    ovh_d  = ovh_q;
    low_d  = low_q;
    crit_d = crit_q;
    flt_src_d = flt_src_q;
    if (done_ok) begin
      res_d = adc_result;
      // Source bit follows kept results only, so a dropped one leaves no trace
      flt_src_d = src_lat_q;
      if (src_lat_q == SRC_TEMP) begin
        hot_d = adc_result > HOT_CODE;
        ovh_d = adc_result > OVH_CODE;
      end else begin
        // Hysteresis keeps the flag steady between set and clear levels
        if (adc_result < LOW_SET) begin
          low_d = 1'b1;
        end else if (adc_result > LOW_CLR) begin
          low_d = 1'b0;
        end
        if (adc_result < CRIT_SET) begin
          crit_d = 1'b1;
        end else if (adc_result > CRIT_CLR) begin
          crit_d = 1'b0;
        end
      end
    end
    alert_d = ovh_d | crit_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_q   <= '0;
      hot_q   <= 1'b0;
      ovh_q   <= 1'b0;
      low_q   <= 1'b0;
      crit_q  <= 1'b0;
      alert_q <= 1'b0;
      flt_src_q <= 1'b0;
    end else begin
      res_q   <= res_d;
      hot_q   <= hot_d;
      ovh_q   <= ovh_d;
      low_q   <= low_d;
      crit_q  <= crit_d;
      alert_q <= alert_d;
      flt_src_q <= flt_src_d;
    end
  end

  // Strap decode
  always_comb begin
    unsup_d = 1'b0;
    case (straps.clean[4:3])
      2'h0:    span_d = SPAN_4_20;
      2'h2:    span_d = SPAN_32_24;
      default: span_d = SPAN_38_21;
    endcase
    case (straps.clean[2:0])
      3'h0:    lvl_d = LVL_1V8;
      3'h1:    lvl_d = LVL_2V5;
      3'h2:    lvl_d = LVL_3V0;
      3'h3:    lvl_d = LVL_3V3;
      3'h4:    lvl_d = LVL_5V0;
      3'h5:    lvl_d = LVL_9V0;
      3'h6:    lvl_d = LVL_12V0;
      default: begin
        lvl_d   = LVL_NONE;
        unsup_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      span_q  <= SPAN_4_20;
      lvl_q   <= LVL_NONE;
      unsup_q <= 1'b0;
    end else begin
      span_q  <= span_d;
      lvl_q   <= lvl_d;
      unsup_q <= unsup_d;
    end
  end

  // Converter controls; power also held while a commanded conversion runs
  logic pwr_q, srcpin_q, start_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_q    <= 1'b0;
      srcpin_q <= 1'b0;
      start_q  <= 1'b0;
    end else begin
      pwr_q    <= ctrl_d[CTRL_PWR_BIT] | (st_d != ADC_IDLE) | req_d;
      srcpin_q <= (st_d == ADC_IDLE) ? ctrl_d[CTRL_SRC_BIT] : src_lat_d;
      start_q  <= (st_d == ADC_START);
    end
  end

  assign prdata                      = rdata_q;
  assign pready                      = rdy_q;
  assign pslverr                     = err_q;
  assign adc_power_on                = pwr_q;
  assign adc_source_temp             = srcpin_q;
  assign adc_start                   = start_q;
  assign span_code                   = span_q;
  assign regulator_decivolts         = lvl_q;
  assign regulator_level_unsupported = unsup_q;
  assign fault_alert                 = alert_q;
  assign irq                         = irq_q;

endmodule

// ==== verilog/fmac_pkg.sv ====
/*
  Constants and types shared by the fault monitor and converter control block.
  Assumes a single 25 MHz core clock and a 32-bit APB register port.
*/
package fmac_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_FAULT  = 8'h08;
  localparam logic [7:0] OFF_STRAP  = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;

  // Control register fields
  localparam int CTRL_PWR_BIT  = 7;   // Converter power
  localparam int CTRL_SRC_BIT  = 8;   // Converter source, 1 = die temperature
  localparam int CTRL_AUTO_BIT = 9;   // Automatic fault readback
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic SRC_TEMP = 1'b1;

  // Conversion command byte
  localparam logic [7:0] CMD_CONVERT = 8'h08;

  // Fault register fields
  localparam int FLT_HOT_BIT  = 16;
  localparam int FLT_OVH_BIT  = 17;
  localparam int FLT_LOW_BIT  = 18;
  localparam int FLT_CRIT_BIT = 19;
  localparam int FLT_SRC_BIT  = 20;

  // Strap register fields
  localparam int STR_LEVEL_LSB = 4;
  localparam int STR_UNSUP_BIT = 8;

  // Status and mask bits
  localparam int ST_HOT  = 0;
  localparam int ST_OVH  = 1;
  localparam int ST_LOW  = 2;
  localparam int ST_CRIT = 3;
  localparam int ST_CONV = 4;
  localparam int ST_W    = 5;
  localparam logic [4:0] MASK_RST = 5'h00;

  // Temperature limits, degrees C
  localparam int TEMP_HOT_C = 100;
  localparam int TEMP_OVH_C = 140;

  // Source switch settling window
  localparam int SETTLE_US  = 30;
  localparam int CLK_KHZ    = 25000;
  localparam int SETTLE_CYC = (SETTLE_US * CLK_KHZ) / 1000;
  localparam int SETTLE_W   = 10;

  // Loop current span codes
  localparam logic [1:0] SPAN_4_20   = 2'h0;
  localparam logic [1:0] SPAN_38_21  = 2'h1;
  localparam logic [1:0] SPAN_32_24  = 2'h2;

  // Regulator output levels in tenths of a volt
  localparam logic [7:0] LVL_1V8  = 8'h12;
  localparam logic [7:0] LVL_2V5  = 8'h19;
  localparam logic [7:0] LVL_3V0  = 8'h1E;
  localparam logic [7:0] LVL_3V3  = 8'h21;
  localparam logic [7:0] LVL_5V0  = 8'h32;
  localparam logic [7:0] LVL_9V0  = 8'h5A;
  localparam logic [7:0] LVL_12V0 = 8'h78;
  localparam logic [7:0] LVL_NONE = 8'h00;

  // Converter sequencer states
  typedef enum logic [1:0] {ADC_IDLE, ADC_START, ADC_WAIT} fmac_adc_state_t;

endpackage

// ==== verilog/fmac_strap_if.sv ====
/*
  Carries the raw strap levels to the synchroniser and the filtered levels back.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/100ps
interface fmac_strap_if #(
  parameter int W = 5
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport user (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// ==== verilog/fmac_strap_sync.sv ====
/*
  Three-stage synchroniser and agreement filter for static strap pins.
  Assumes synchronous active-high reset on the core clock.
*/
`timescale 1ns/100ps
module fmac_strap_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strap levels
  fmac_strap_if.sync straps
);
  localparam int W = $bits(straps.raw);

  logic [W-1:0] ff1_q, ff2_q, ff3_q, clean_q;
  logic [W-1:0] clean_d;

  // A change only counts once the second and third stage agree
  always_comb begin
    clean_d = clean_q;
    if (ff2_q == ff3_q) begin
      clean_d = ff3_q;
    end
  end

  // Stage one feeds only stage two
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ff1_q   <= '0;
      ff2_q   <= '0;
      ff3_q   <= '0;
      clean_q <= '0;
    end else begin
      ff1_q   <= straps.raw;
      ff2_q   <= ff1_q;
      ff3_q   <= ff2_q;
      clean_q <= clean_d;
    end
  end

  assign straps.clean = clean_q;
endmodule

// ==== test/fmac_adc_model.sv ====
/*
  Converter stand-in: answers each start pulse four cycles later with next_code.
  Assumes the core clock and the block's synchronous reset.
*/
`timescale 1ns/100ps
module fmac_adc_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Converter pins
  input  wire logic        adc_start,
  input  wire logic [11:0] next_code,
  output logic             adc_done,
  output logic      [11:0] adc_result
);
  logic [2:0] busy_q;

  // Result toggles outside done so a stale code is never mistaken for valid
  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_result <= ~adc_result;
    if (rst) begin
      busy_q <= 3'h0;
      adc_result <= 12'h5A5;
    end else if (adc_start) begin
      busy_q <= 3'h4;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
      if (busy_q == 3'h1) begin
        adc_done <= 1'b1;
        adc_result <= next_code;
      end
    end
  end
endmodule

// ==== test/fmac_top_asserts.sv ====
/*
  Port checker for the fault monitor top.
  Assumes one core clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module fmac_top_asserts
  import fmac_pkg::*;
#(
  parameter int          ADC_W    = 12,
  parameter logic [11:0] OVH_CODE = 12'hC00,
  parameter logic [11:0] CRIT_SET = 12'h1EB
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst,
  // APB
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Converter
  input wire logic             adc_done,
  input wire logic [ADC_W-1:0] adc_result,
  input wire logic             adc_power_on,
  input wire logic             adc_source_temp,
  input wire logic             adc_start,
  // Decode and alert
  input wire logic [7:0]       regulator_decivolts,
  input wire logic             regulator_level_unsupported,
  input wire logic             fault_alert
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       src_q;
  logic [9:0] since_q;

  // Age of the temperature source; early results may be discarded
  always_ff @(posedge core_clk) begin
    src_q <= adc_source_temp;
    if (rst || (adc_source_temp && !src_q)) since_q <= 10'h000;
    else if (since_q != 10'h3FF) since_q <= since_q + 10'h001;
  end

  a_ovh_alert: assert property (
    adc_done && adc_source_temp && since_q >= 10'h320 && adc_result > OVH_CODE
    |-> ##[1:3] fault_alert) else $error("overheat without alert");
  a_hot_quiet: assert property (
    adc_done && adc_source_temp && !fault_alert && adc_result <= OVH_CODE
    |-> ##1 !fault_alert [*3]) else $error("alert without overheat");
  a_crit_alert: assert property (
    adc_done && !adc_source_temp && adc_result < CRIT_SET
    |-> ##[1:3] fault_alert) else $error("critical without alert");
  a_low_quiet: assert property (
    adc_done && !adc_source_temp && !fault_alert && adc_result >= CRIT_SET
    |-> ##1 !fault_alert [*3]) else $error("alert from low supply");
  a_cmd_start: assert property (
    psel && penable && pready && pwrite && paddr == OFF_CMD && !adc_power_on
    && pwdata[7:0] == CMD_CONVERT |-> ##[1:4] adc_start) else $error("no start");
  a_start_power: assert property (
    adc_start |-> adc_power_on ##1 !adc_start) else $error("start not powered");
  a_one_wait: assert property (
    psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state");
  a_unmapped: assert property (
    pready |-> pslverr == !(paddr == OFF_CTRL || paddr == OFF_CMD || paddr == OFF_FAULT ||
    paddr == OFF_STRAP || paddr == OFF_STATUS || paddr == OFF_MASK)) else $error("slave error");
  a_unsup_none: assert property (
    regulator_level_unsupported |-> regulator_decivolts == LVL_NONE) else $error("level");
endmodule

bind fmac_top fmac_top_asserts #(.ADC_W(ADC_W), .OVH_CODE(OVH_CODE), .CRIT_SET(CRIT_SET)) u_chk (
  .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .adc_done, .adc_result, .adc_power_on, .adc_source_temp, .adc_start,
  .regulator_decivolts, .regulator_level_unsupported, .fault_alert
);

// ==== test/tb_fault_monitor_adc_control.sv ====
/*
  Self-checking bench: straps, supply and temperature faults, interrupts.
  Assumes the converter model beside the block and the bound checker.
*/
`timescale 1ns/100ps
module tb_fault_monitor_adc_control
  import fmac_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  straps = 5'h00;
  logic [11:0] next_code = 12'h000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, adc_done, adc_power_on, adc_source_temp, adc_start;
  logic        unsup, fault_alert, irq, err;
  logic [11:0] adc_result;
  logic [1:0]  span_code;
  logic [7:0]  regulator_decivolts;
  int          failures = 0;
  int          comparisons = 0;

  always #20 core_clk = ~core_clk;

  fmac_top u_dut (
    .core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .adc_done, .adc_result, .adc_power_on, .adc_source_temp, .adc_start,
    .span_sel_msb(straps[4]), .span_sel_lsb(straps[3]), .regulator_level_bit2(straps[2]),
    .regulator_level_bit1(straps[1]), .regulator_level_bit0(straps[0]), .span_code,
    .regulator_decivolts, .regulator_level_unsupported(unsup), .fault_alert, .irq
  );
  fmac_adc_model u_adc (.core_clk, .rst, .adc_start, .next_code, .adc_done, .adc_result);

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A hung handshake ends the run rather than stalling it
  task automatic guard(input int n);
    if (n >= 40) begin
      failures++;
      $display("mismatch at %0t: waited %h limit %h", $time, n, 40);
      tally_and_finish();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer is taken at the very edge where pready is sampled high, then released
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    guard(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One commanded conversion, then alert pin and fault word
  task automatic conv(input logic [11:0] c, input logic [31:0] flt, input logic al);
    int n;
    n = 0;
    apb(1'b1, OFF_CMD, {24'h0, CMD_CONVERT});
    next_code <= c;
    while (adc_done !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    guard(n);
    repeat (3) @(posedge core_clk);
    #1;
    chk({31'h0, fault_alert}, {31'h0, al});
    apb(1'b0, OFF_FAULT, 32'h0);
    chk(rd, flt);
  endtask

  task automatic strap_test();
    logic [7:0] lvl [0:7] = '{LVL_1V8, LVL_2V5, LVL_3V0, LVL_3V3, LVL_5V0, LVL_9V0,
                              LVL_12V0, LVL_NONE};
    logic [1:0] spn [0:3] = '{SPAN_4_20, SPAN_38_21, SPAN_32_24, SPAN_38_21};
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      straps <= {i[1:0], i[2:0]};
      repeat (10) @(posedge core_clk);
      #1;
      chk({24'h0, regulator_decivolts}, {24'h0, lvl[i]});
      chk({30'h0, span_code}, {30'h0, spn[i[1:0]]});
      chk({31'h0, unsup}, {31'h0, i == 7});
      apb(1'b0, OFF_STRAP, 32'h0);
      chk(rd, {23'h0, i == 7, 1'b0, i[2:0], 2'h0, spn[i[1:0]]});
    end
  endtask

  // Boundaries on both sides of each supply threshold, critical set level below only; {alert, crit, low}
  task automatic loop_test();
    logic [11:0] cd [0:6] = '{12'h3D6, 12'h3D5, 12'h1EA, 12'h28F, 12'h290, 12'h47B, 12'h47C};
    logic [2:0]  fl [0:6] = '{3'h0, 3'h1, 3'h7, 3'h7, 3'h1, 3'h1, 3'h0};
    for (int i = 0; i < 7; i++) begin
      conv(cd[i], {12'h0, fl[i][1:0], 6'h0, cd[i]}, fl[i][2]);
    end
  endtask

  task automatic temp_test();
    apb(1'b1, OFF_CTRL, 32'h100);
    conv(12'hFFF, 32'h47C, 1'b0);
    repeat (760) @(posedge core_clk);
    conv(12'hA01, 32'h110A01, 1'b0);
    chk({31'h0, adc_source_temp}, 32'h1);
    conv(12'hC01, 32'h130C01, 1'b1);
    conv(12'hA00, 32'h100A00, 1'b0);
  endtask

  task automatic irq_test();
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h1F);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_MASK, 32'h02);
    apb(1'b0, OFF_MASK, 32'h0);
    chk(rd, 32'h02);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_STATUS, 32'h02);
    @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h1F);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  // Automatic readback: nothing runs unpowered, then results follow the loop supply
  task automatic auto_test();
    next_code <= 12'h3D5;
    apb(1'b1, OFF_CTRL, 32'h200);
    repeat (20) @(posedge core_clk);
    apb(1'b0, OFF_FAULT, 32'h0);
    chk(rd, 32'h100A00);
    apb(1'b1, OFF_CTRL, 32'h280);
    repeat (20) @(posedge core_clk);
    #1;
    chk({31'h0, adc_power_on}, 32'h1);
    apb(1'b0, OFF_FAULT, 32'h0);
    chk(rd, 32'h403D5);
    next_code <= 12'h47C;
    repeat (20) @(posedge core_clk);
    apb(1'b0, OFF_FAULT, 32'h0);
    chk(rd, 32'h47C);
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (20) @(posedge core_clk);
    #1;
    chk({31'h0, adc_power_on}, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    strap_test();
    $display("strap test done");
    loop_test();
    $display("loop supply test done");
    temp_test();
    $display("temperature test done");
    irq_test();
    $display("interrupt test done");
    auto_test();
    $display("auto readback test done");
    tally_and_finish();
  end
endmodule
